// ==== logic/auto_param_set_sequencer.sv ====
// automatic-advance parameter-set sequencer with apb register file
// assumes frame_trig and frame_done are one-cycle pulses synchronous to pclk
//
// Overview of operation
// - while running, slots advance only when frame triggers arrive, nothing else needed
// - slots are walked upward, each used its repeat count of frames
// - after the last slot's final use the next trigger loads slot 0
// - slot count sets slots per cycle, limited to 64
// - enabling loads slot 0, the first trigger then uses slot 0
// - each trigger reuses the slot while uses remain, else loads the next
// - disabling mid-frame finishes that frame before cycling stops
// - on stopping the active parameters return to pre-sequencing values
// - slot selector takes indices 0 to 63
// - repeat count takes values 1 to 256
// - while idle, save command copies active parameters into the selected slot
// - never-stored slots inside the count deliver default values
// - slot contents are lost at every reset
// - while running, host cannot change active params, readback shows old
`timescale 1ns/1ps
module auto_param_set_sequencer (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [seq_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic frame_trig,
    input wire logic frame_done,
    output logic [seq_pkg::PARAM_W-1:0] active_param,
    output logic [seq_pkg::IDX_W-1:0] active_slot,
    output logic expose_go,
    output logic seq_running
);
    import seq_pkg::*;

    // ----------------------------------------------------------------
    // decode helpers
    // ----------------------------------------------------------------
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] o);
        return a == o;
    endfunction

    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        return hit(a, OFS_CTRL) | hit(a, OFS_COUNT) | hit(a, OFS_SEL) | hit(a, OFS_REP) |
               hit(a, OFS_CMD) | hit(a, OFS_PARAM) | hit(a, OFS_STATUS);
    endfunction

    function automatic logic [CNT_W-1:0] clamp_count(input logic [31:0] v);
        if (v == 32'h0) return COUNT_MIN;
        else if (v > {25'h0, COUNT_MAX}) return COUNT_MAX;
        else return v[CNT_W-1:0];
    endfunction

    function automatic logic [REP_W-1:0] clamp_rep(input logic [31:0] v);
        if (v == 32'h0) return REP_MIN;
        else if (v > {23'h0, REP_MAX}) return REP_MAX;
        else return v[REP_W-1:0];
    endfunction

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    seq_state_t state_r;
    logic run_on_r;
    logic policy_r;
    logic [CNT_W-1:0] slot_count_r;
    logic [IDX_W-1:0] slot_sel_r;
    logic [REP_W-1:0] slot_rep_r;
    logic [PARAM_W-1:0] host_param_r;
    logic [SLOTS-1:0] valid_r;
    logic [IDX_W-1:0] cur_r;
    logic [REP_W-1:0] uses_r;
    logic [REP_W-1:0] cur_rep_r;
    logic load_pend_r;
    logic rd_valid_r;
    logic go_pend_r;
    logic busy;
    logic setup_w;
    logic wr_w;
    logic save_w;
    logic restore_w;
    logic advance_w;
    logic reuse_w;
    logic wrap_w;
    logic [IDX_W-1:0] next_idx;
    logic [IDX_W-1:0] mem_addr;
    logic [REP_W-1:0] rep_now;
    logic [31:0] rd_val;
    slot_word_t mem_q;
    slot_word_t loaded_w;
    slot_word_t save_word;

    assign setup_w = psel & penable & ~pready;
    assign wr_w = psel & penable & pready & pwrite;
    // saving while running would race the slot reads, so it is ignored
    assign save_w = wr_w & hit(paddr, OFS_CMD) & pwdata[CMD_SAVE_BIT] & (state_r == ST_IDLE);
    assign save_word = '{rep: slot_rep_r, param: host_param_r};

    // ----------------------------------------------------------------
    // sequencing decisions
    // ----------------------------------------------------------------
    assign loaded_w = rd_valid_r ? mem_q : DEFAULT_WORD;
    // a load still in flight carries the repeat count of the new slot
    assign rep_now = load_pend_r ? loaded_w.rep : cur_rep_r;
    assign wrap_w = ({1'b0, cur_r} + 7'h01) >= slot_count_r;
    assign next_idx = wrap_w ? '0 : cur_r + 6'h01;
    assign reuse_w = (state_r == ST_RUN) & run_on_r & frame_trig & (uses_r < rep_now);
    assign advance_w = (state_r == ST_RUN) & run_on_r & frame_trig & ~(uses_r < rep_now);
    assign restore_w = ((state_r == ST_RUN) & ~run_on_r & ~busy) |
                       ((state_r == ST_STOP) & ~busy);
    assign mem_addr = save_w ? slot_sel_r : ((state_r == ST_START) ? '0 : next_idx);

    slot_mem u_mem (
        .pclk(pclk),
        .presetn(presetn),
        .we(save_w),
        .addr(mem_addr),
        .wdata(save_word),
        .rdata(mem_q)
    );

    frame_tracker u_track (
        .pclk(pclk),
        .presetn(presetn),
        .frame_trig(frame_trig),
        .frame_done(frame_done),
        .busy(busy)
    );

    // ----------------------------------------------------------------
    // apb slave, one wait state on every access
    // ----------------------------------------------------------------
    always_comb begin
        rd_val = 32'h0;
        if (hit(paddr, OFS_CTRL)) begin
            rd_val[CTRL_RUN_BIT] = run_on_r;
            rd_val[CTRL_POLICY_BIT] = policy_r;
        end else if (hit(paddr, OFS_COUNT)) begin
            rd_val[CNT_W-1:0] = slot_count_r;
        end else if (hit(paddr, OFS_SEL)) begin
            rd_val[IDX_W-1:0] = slot_sel_r;
        end else if (hit(paddr, OFS_REP)) begin
            rd_val[REP_W-1:0] = slot_rep_r;
        end else if (hit(paddr, OFS_PARAM)) begin
            rd_val = host_param_r;
        end else if (hit(paddr, OFS_STATUS)) begin
            rd_val[STAT_RUN_BIT] = seq_running;
            rd_val[STAT_STOP_BIT] = (state_r == ST_STOP);
            rd_val[STAT_SLOT_LSB +: IDX_W] = cur_r;
            rd_val[STAT_USES_LSB +: REP_W] = uses_r;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h0;
            pslverr <= 1'b0;
        end else begin
            pready <= setup_w;
            pslverr <= setup_w & ~mapped(paddr);
            prdata <= (setup_w & ~pwrite) ? rd_val : 32'h0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_on_r <= 1'b0;
            policy_r <= POLICY_AUTO;
            slot_count_r <= COUNT_RST;
            slot_sel_r <= '0;
            slot_rep_r <= REP_RST;
            host_param_r <= PARAM_RST;
        end else if (wr_w) begin
            if (hit(paddr, OFS_CTRL)) begin
                run_on_r <= pwdata[CTRL_RUN_BIT];
                policy_r <= pwdata[CTRL_POLICY_BIT];
            end
            if (hit(paddr, OFS_COUNT)) begin
                slot_count_r <= clamp_count(pwdata);
            end
            if (hit(paddr, OFS_SEL)) begin
                slot_sel_r <= pwdata[IDX_W-1:0];
            end
            if (hit(paddr, OFS_REP)) begin
                slot_rep_r <= clamp_rep(pwdata);
            end
            if (hit(paddr, OFS_PARAM) && state_r == ST_IDLE) begin
                host_param_r <= pwdata;
            end
        end
    end

    // slot contents count as lost at reset since nothing is marked stored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            valid_r <= '0;
            rd_valid_r <= 1'b0;
        end else begin
            if (save_w) begin
                valid_r[slot_sel_r] <= 1'b1;
            end
            rd_valid_r <= valid_r[mem_addr];
        end
    end

    // ----------------------------------------------------------------
    // run control
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ST_IDLE;
            seq_running <= 1'b0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    // only the automatic policy is built; others never start
                    if (run_on_r && policy_r == POLICY_AUTO) begin
                        state_r <= ST_START;
                        seq_running <= 1'b1;
                    end
                end
                ST_START: begin
                    state_r <= ST_RUN;
                end
                ST_RUN: begin
                    if (!run_on_r) begin
                        state_r <= busy ? ST_STOP : ST_IDLE;
                        seq_running <= busy;
                    end
                end
                ST_STOP: begin
                    if (!busy) begin
                        state_r <= ST_IDLE;
                        seq_running <= 1'b0;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                    seq_running <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur_r <= '0;
            uses_r <= '0;
            load_pend_r <= 1'b0;
        end else if (state_r == ST_START) begin
            cur_r <= '0;
            uses_r <= frame_trig ? 9'h001 : 9'h000;
            load_pend_r <= 1'b1;
        end else if (advance_w) begin
            cur_r <= next_idx;
            uses_r <= 9'h001;
            load_pend_r <= 1'b1;
        end else begin
            load_pend_r <= 1'b0;
            if (reuse_w) begin
                uses_r <= uses_r + 9'h001;
            end
        end
    end

    // ----------------------------------------------------------------
    // active set and exposure start
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            active_param <= PARAM_RST;
            active_slot <= '0;
            cur_rep_r <= REP_RST;
        end else if (restore_w || state_r == ST_IDLE) begin
            active_param <= host_param_r;
            active_slot <= '0;
            cur_rep_r <= REP_RST;
        end else if (load_pend_r) begin
            active_param <= loaded_w.param;
            active_slot <= cur_r;
            cur_rep_r <= loaded_w.rep;
        end
    end

    // the extra stage gives the slot read time to land before exposure
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            go_pend_r <= 1'b0;
            expose_go <= 1'b0;
        end else begin
            go_pend_r <= frame_trig;
            expose_go <= go_pend_r;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_NO_TRIG_HOLD: assert property ((state_r == ST_RUN && !frame_trig) |=> cur_r == $past(cur_r))
        else $error("slot changed without a trigger");
    AST_ASCEND: assert property ((advance_w && !wrap_w) |=> cur_r == $past(cur_r) + 6'h01)
        else $error("slot did not step up by one");
    AST_WRAP: assert property ((advance_w && wrap_w) |=> cur_r == '0)
        else $error("slot did not wrap to zero");
    AST_COUNT_RANGE: assert property (slot_count_r >= COUNT_MIN && slot_count_r <= COUNT_MAX)
        else $error("slot count out of range");
    AST_START_SLOT0: assert property ((state_r == ST_START) |=> (cur_r == '0 && load_pend_r) ##1 active_slot == '0)
        else $error("start did not load slot zero");
    AST_REUSE: assert property (reuse_w |=> (cur_r == $past(cur_r) && uses_r == $past(uses_r) + 9'h001))
        else $error("slot reuse miscounted");
    AST_STOP_WAITS: assert property ((state_r == ST_STOP && busy) |=> seq_running)
        else $error("stopped before frame finished");
    AST_RESTORE: assert property (restore_w |=> (active_param == $past(host_param_r) && !seq_running))
        else $error("active params not restored");
    AST_REP_RANGE: assert property (slot_rep_r >= REP_MIN && slot_rep_r <= REP_MAX)
        else $error("repeat count out of range");
    AST_DEFAULT: assert property ((load_pend_r && !rd_valid_r && !restore_w && state_r != ST_IDLE)
                                  |=> active_param == DEFAULT_WORD.param)
        else $error("unstored slot not defaulted");
    AST_HOST_LOCK: assert property ((wr_w && hit(paddr, OFS_PARAM) && state_r != ST_IDLE)
                                    |=> host_param_r == $past(host_param_r))
        else $error("host param changed while running");
    AST_USES_CLEAR: assert property (advance_w |=> uses_r == 9'h001)
        else $error("use count not cleared on new slot");
    AST_LOAD_BEFORE_GO: assert property (advance_w |=> ##1 (expose_go && active_slot == $past(cur_r)))
        else $error("exposure started before slot loaded");

    COV_ADVANCE: cover property (advance_w && !wrap_w);
    COV_WRAP: cover property (advance_w && wrap_w);
    COV_REUSE_RUN: cover property (reuse_w ##1 reuse_w);
    COV_STOP_PENDING: cover property (state_r == ST_STOP ##1 restore_w);

endmodule // auto_param_set_sequencer

// ==== logic/frame_tracker.sv ====
// counts frames between trigger and end of transmission
// assumes frame_done pulses once per triggered frame
`timescale 1ns/1ps
module frame_tracker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic frame_trig,
    input wire logic frame_done,
    output logic busy
);
    import seq_pkg::*;

    logic [FLIGHT_W-1:0] inflight_r;
    logic [FLIGHT_W-1:0] inflight_nxt;

    always_comb begin
        inflight_nxt = inflight_r;
        if (frame_trig && !frame_done && inflight_r != '1) begin
            inflight_nxt = inflight_r + 4'h1;
        end else if (frame_done && !frame_trig && inflight_r != '0) begin
            inflight_nxt = inflight_r - 4'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            inflight_r <= '0;
            busy <= 1'b0;
        end else begin
            inflight_r <= inflight_nxt;
            busy <= (inflight_nxt != '0);
        end
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_TRIG_MAKES_BUSY: assert property (frame_trig |=> busy)
        else $error("frame in flight not flagged busy");

endmodule // frame_tracker

// ==== logic/slot_mem.sv ====
// storage for the 64 parameter slots, registered read
// assumes one write or one read per cycle, the owner arbitrates
`timescale 1ns/1ps
module slot_mem (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic we,
    input wire logic [seq_pkg::IDX_W-1:0] addr,
    input wire seq_pkg::slot_word_t wdata,
    output seq_pkg::slot_word_t rdata
);
    import seq_pkg::*;

    // contents carry no reset; validity is tracked by the owner
    slot_word_t mem_r [SLOTS];

    always_ff @(posedge pclk) begin
        if (we) begin
            mem_r[addr] <= wdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata <= '0;
        end else begin
            rdata <= mem_r[addr];
        end
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_MEM_STORE: assert property (we ##1 (addr == $past(addr)) |=> rdata == $past(wdata, 2))
        else $error("stored slot word not read back");

endmodule // slot_mem

// ==== pkg/seq_pkg.sv ====
// shared constants, field layouts and types of the parameter-set sequencer
// assumes a 32-bit apb register bus and a single 250 mhz clock
package seq_pkg;

    // ----------------------------------------------------------------
    // sizes and timing
    // ----------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam int PARAM_W = 32;
    localparam int IDX_W = 6;
    localparam int CNT_W = 7;
    localparam int REP_W = 9;
    localparam int SLOTS = 64;
    localparam int FLIGHT_W = 4;
    localparam real CLK_MHZ = 250.0;
    // edges from trigger sample to exposure start, params already loaded
    localparam int GO_LAT_CYC = 2;

    // ----------------------------------------------------------------
    // register offsets (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_CTRL = 12'h000;
    localparam logic [ADDR_W-1:0] OFS_COUNT = 12'h004;
    localparam logic [ADDR_W-1:0] OFS_SEL = 12'h008;
    localparam logic [ADDR_W-1:0] OFS_REP = 12'h00c;
    localparam logic [ADDR_W-1:0] OFS_CMD = 12'h010;
    localparam logic [ADDR_W-1:0] OFS_PARAM = 12'h014;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h018;

    // ----------------------------------------------------------------
    // field positions and reset values
    // ----------------------------------------------------------------
    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_POLICY_BIT = 1;
    localparam int CMD_SAVE_BIT = 0;
    localparam int STAT_RUN_BIT = 0;
    localparam int STAT_STOP_BIT = 1;
    localparam int STAT_SLOT_LSB = 8;
    localparam int STAT_USES_LSB = 16;
    localparam logic POLICY_AUTO = 1'b0;
    localparam logic [CNT_W-1:0] COUNT_MIN = 7'h01;
    localparam logic [CNT_W-1:0] COUNT_MAX = 7'h40;
    localparam logic [CNT_W-1:0] COUNT_RST = 7'h01;
    localparam logic [REP_W-1:0] REP_MIN = 9'h001;
    localparam logic [REP_W-1:0] REP_MAX = 9'h100;
    localparam logic [REP_W-1:0] REP_RST = 9'h001;
    localparam logic [PARAM_W-1:0] PARAM_RST = 32'h0000_0000;

    typedef struct packed {
        logic [REP_W-1:0] rep;
        logic [PARAM_W-1:0] param;
    } slot_word_t;

    // what a never-stored slot delivers
    localparam slot_word_t DEFAULT_WORD = '{rep: 9'h001, param: 32'h0000_0000};

    typedef enum logic [1:0] {ST_IDLE, ST_START, ST_RUN, ST_STOP} seq_state_t;

endpackage

// ==== verif/tb_auto_param_set_sequencer.sv ====
// self-checking bench for the automatic-advance parameter-set sequencer
// assumes seq_pkg is compiled first; drives apb and the frame pulses directly
`timescale 1ns/1ps
module tb_auto_param_set_sequencer;
    import seq_pkg::*;

    // ----------------------------------------------------------------
    // signals
    // ----------------------------------------------------------------
    logic pclk, presetn, psel, penable, pwrite, frame_trig, frame_done;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr, err, expose_go, seq_running;
    logic [PARAM_W-1:0] active_param;
    logic [IDX_W-1:0] active_slot;
    int fail_count = 0;
    int num_checks = 0;
    localparam logic [31:0] P_A = 32'h1234_5678;
    localparam logic [31:0] P_B = 32'h0bad_cafe;
    localparam logic [31:0] P_H = 32'h00c0_ffee;
    localparam logic [31:0] P_X = 32'hdead_0001;

    auto_param_set_sequencer DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .frame_trig(frame_trig),
        .frame_done(frame_done), .active_param(active_param),
        .active_slot(active_slot), .expose_go(expose_go), .seq_running(seq_running)
    );

    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // request held until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // no cycle budget here, the watchdog ends a slave that never answers
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdchk(input string what, input logic [ADDR_W-1:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(what, exp, rd);
    endtask

    // trigger, then look at the cycle one edge after the sampling edge
    task automatic trig(input logic [IDX_W-1:0] s, input logic [31:0] p, input bit done);
        @(posedge pclk);
        frame_trig <= 1'b1;
        @(posedge pclk);
        frame_trig <= 1'b0;
        @(posedge pclk);
        #1;
        check("expose_go", 32'h1, {31'h0, expose_go});
        check("active_slot", 32'(s), 32'(active_slot));
        check("active_param", p, active_param);
        if (done) begin
            @(posedge pclk);
            frame_done <= 1'b1;
            @(posedge pclk);
            frame_done <= 1'b0;
        end
    endtask

    task automatic settle;
        repeat (4) @(posedge pclk);
        #1;
    endtask

    // ----------------------------------------------------------------
    // watchdog, sized well above the few hundred cycles the tests take
    // ----------------------------------------------------------------
    initial begin
        repeat (20000) @(posedge pclk);
        fail_count++;
        give_verdict();
    end

    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, frame_trig, frame_done} = 5'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;

        rdchk("count reset", OFS_COUNT, 32'(COUNT_RST));
        rdchk("repeat reset", OFS_REP, 32'(REP_RST));
        rdchk("cmd reads", OFS_CMD, 32'h0);
        apb(1'b0, 12'h002, 32'h0);
        check("unaligned err", 32'h1, {31'h0, err});
        apb(1'b1, OFS_COUNT, 32'h0);
        rdchk("count low clamp", OFS_COUNT, 32'(COUNT_MIN));
        apb(1'b1, OFS_COUNT, 32'h64);
        rdchk("count high clamp", OFS_COUNT, 32'(COUNT_MAX));
        apb(1'b1, OFS_REP, 32'h0);
        rdchk("repeat low clamp", OFS_REP, 32'(REP_MIN));
        apb(1'b1, OFS_REP, 32'h100);
        rdchk("repeat top", OFS_REP, 32'(REP_MAX));
        apb(1'b1, OFS_SEL, 32'h3f);
        rdchk("selector top", OFS_SEL, 32'h3f);
        $display("test ranges done");

        // slot 0 once, slot 1 three times, slot 2 left unstored
        apb(1'b1, OFS_PARAM, P_A);
        apb(1'b1, OFS_SEL, 32'h0);
        apb(1'b1, OFS_REP, 32'h1);
        apb(1'b1, OFS_CMD, 32'h1);
        apb(1'b1, OFS_PARAM, P_B);
        apb(1'b1, OFS_SEL, 32'h1);
        apb(1'b1, OFS_REP, 32'h3);
        apb(1'b1, OFS_CMD, 32'h1);
        apb(1'b1, OFS_COUNT, 32'h3);
        apb(1'b1, OFS_PARAM, P_H);
        apb(1'b1, OFS_CTRL, 32'h1);
        settle();
        check("running", 32'h1, {31'h0, seq_running});
        check("slot0 loaded", P_A, active_param);
        trig(6'h0, P_A, 1'b1);
        for (int i = 0; i < 3; i++) begin
            trig(6'h1, P_B, 1'b1);
        end
        trig(6'h2, DEFAULT_WORD.param, 1'b1);
        trig(6'h0, P_A, 1'b1);
        trig(6'h1, P_B, 1'b1);
        rdchk("status", OFS_STATUS, 32'h0001_0101);
        apb(1'b1, OFS_PARAM, P_X);
        rdchk("param hidden", OFS_PARAM, P_H);
        check("active kept", P_B, active_param);
        $display("test auto advance done");

        // stop requested while a frame is still in flight
        trig(6'h1, P_B, 1'b0);
        apb(1'b1, OFS_CTRL, 32'h0);
        settle();
        check("stop pending", 32'h1, {31'h0, seq_running});
        check("param in flight", P_B, active_param);
        @(posedge pclk);
        frame_done <= 1'b1;
        @(posedge pclk);
        frame_done <= 1'b0;
        settle();
        check("stopped", 32'h0, {31'h0, seq_running});
        check("restored", P_H, active_param);
        trig(6'h0, P_H, 1'b1);
        $display("test stop done");

        // a policy other than automatic must never start sequencing
        apb(1'b1, OFS_CTRL, 32'h3);
        rdchk("ctrl policy", OFS_CTRL, 32'h3);
        settle();
        check("other policy idle", 32'h0, {31'h0, seq_running});
        apb(1'b1, OFS_CTRL, 32'h0);
        $display("test policy done");

        // reset in mid-run must forget stored slot 0, the only slot read back after reset
        apb(1'b1, OFS_CTRL, 32'h1);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        check("reset param", 32'(PARAM_RST), active_param);
        check("reset running", 32'h0, {31'h0, seq_running});
        presetn <= 1'b1;
        apb(1'b1, OFS_PARAM, P_H);
        apb(1'b1, OFS_CTRL, 32'h1);
        settle();
        check("slots lost", DEFAULT_WORD.param, active_param);
        rdchk("host param", OFS_PARAM, P_H);
        $display("test reset done");
        give_verdict();
    end
endmodule // tb_auto_param_set_sequencer
